//--- rtl/mbpm_pkg.sv
// Constants, register map and types for the match based pulse modulator
// Behaviour
// - Counter advances each pclk and compares against seven match registers.
// - Cycle match register match resets counter, setting shared period.
// - Single-edge output uses cycle match plus one edge match register.
// - Single-edge outputs go high at cycle start unless forced constantly low.
// - Double-edge output uses cycle match plus two edge match registers.
// - Rise before fall gives positive pulse; fall before rise gives negative.
// - Up to six single-edge, three double-edge, or a fitting mix.
// - Any match may let the counter continue, optional interrupt flag.
// - Any match may stop the counter, optional interrupt flag.
// - Any match may reset the counter to zero, optional interrupt flag.
// - Period and width are any whole count; all outputs share rate.
// - Double-edge edges placed anywhere in the cycle independently.
package mbpm_pkg;
    localparam int          NUM_MATCH   = 7;
    localparam int          NUM_OUT     = 6;
    localparam int          CNT_W       = 32;
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_COUNT   = 12'h004;
    localparam logic [11:0] OFS_MCTRL   = 12'h008;
    localparam logic [11:0] OFS_IFLAG   = 12'h00C;
    localparam logic [11:0] OFS_OCTRL   = 12'h010;
    localparam logic [11:0] OFS_OUTSTAT = 12'h014;
    localparam logic [11:0] OFS_MATCH0  = 12'h020;
    localparam logic [31:0] CNT_ZERO    = 32'h00000000;
    localparam logic [31:0] CNT_ONE     = 32'h00000001;
    // Control register bits
    localparam int          CTRL_RUN    = 0;
    localparam int          CTRL_CLR    = 1;
    // Match control: three bits per match register
    localparam int          MC_IRQ      = 0;
    localparam int          MC_RST      = 1;
    localparam int          MC_STOP     = 2;
    localparam int          MC_W        = 3;
    // Output control: double-edge select in low bits, enable above
    localparam int          OC_EN_LSB   = 8;

    typedef struct packed {
        logic [NUM_MATCH-1:0] irq;
        logic [NUM_MATCH-1:0] rst;
        logic [NUM_MATCH-1:0] stop;
    } mbpm_mctrl_t;

    typedef struct packed {
        logic [NUM_OUT-1:0] en;
        logic [NUM_OUT-1:0] dbl;
    } mbpm_octrl_t;
endpackage

//--- rtl/mbpm_top.sv
// Match based pulse modulator: APB slave, counter, match logic and outputs
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module mbpm_top
    import mbpm_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic      [NUM_OUT:1]   pwm_out,
    output logic                    irq_pending
);
    logic [CNT_W-1:0]      count;
    logic                  run;
    logic [CNT_W-1:0]      match_val [NUM_MATCH];
    mbpm_mctrl_t           mctrl;
    mbpm_octrl_t           octrl;
    logic [NUM_MATCH-1:0]  iflag;
    logic [NUM_MATCH-1:0]  hit;
    logic                  any_rst;
    logic                  any_stop;
    logic                  wr_en;
    logic                  rd_en;
    logic                  addr_ok;
    logic [NUM_OUT:1]      next_out;
    logic [NUM_MATCH-1:0]  irq_hit;
    logic [NUM_MATCH-1:0]  clr_mask;
    logic [NUM_MATCH-1:0]  clr_only;
    logic                  any_irq_hit;
    logic                  ctrl_wr;

    // Match register index of an address, or NUM_MATCH when it is none
    function automatic int match_index(input logic [11:0] a);
        int idx;
        idx = NUM_MATCH;
        for (int k = 0; k < NUM_MATCH; k++) begin
            if (a == OFS_MATCH0 + 12'(4 * k)) begin
                idx = k;
            end
        end
        return idx;
    endfunction

    // Address decode; unmapped addresses answer with pslverr
    always_comb begin
        addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_COUNT) || (paddr == OFS_MCTRL)
               || (paddr == OFS_IFLAG) || (paddr == OFS_OCTRL)
               || (paddr == OFS_OUTSTAT) || (match_index(paddr) != NUM_MATCH);
    end

    // Zero wait state slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en   = psel & penable & pwrite & addr_ok;
    assign rd_en   = psel & ~penable & ~pwrite;

    // Compare each match register against the live count
    genvar g;
    generate
        for (g = 0; g < NUM_MATCH; g++) begin : g_cmp
            assign hit[g] = run && (count == match_val[g]);
        end
    endgenerate

    assign any_rst  = |(hit & mctrl.rst);
    assign any_stop = |(hit & mctrl.stop);

    // Match registers; software must program the cycle one with reset enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < NUM_MATCH; k++) begin
                match_val[k] <= CNT_ZERO;
            end
        end else if (wr_en && match_index(paddr) != NUM_MATCH) begin
            match_val[match_index(paddr)] <= pwdata;
        end
    end

    // Match actions and output mode configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mctrl <= '0;
            octrl <= '0;
        end else if (wr_en && paddr == OFS_MCTRL) begin
            for (int k = 0; k < NUM_MATCH; k++) begin
                mctrl.irq[k]  <= pwdata[MC_W*k + MC_IRQ];
                mctrl.rst[k]  <= pwdata[MC_W*k + MC_RST];
                mctrl.stop[k] <= pwdata[MC_W*k + MC_STOP];
            end
        end else if (wr_en && paddr == OFS_OCTRL) begin
            octrl.dbl <= pwdata[NUM_OUT-1:0];
            octrl.en  <= pwdata[OC_EN_LSB +: NUM_OUT];
        end
    end

    // Run bit: software starts it, a stop match clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
        end else if (any_stop) begin
            run <= 1'b0;
        end else if (wr_en && paddr == OFS_CTRL) begin
            run <= pwdata[CTRL_RUN];
        end
    end

    // Counter; clear write or reset match returns to zero, a stop match holds it, otherwise counts while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= CNT_ZERO;
        end else if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLR]) begin
            count <= CNT_ZERO;
        end else if (any_rst) begin
            count <= CNT_ZERO;
        end else if (run && !any_stop) begin
            count <= count + CNT_ONE;
        end
    end

    // Pending flags: a match in the clearing cycle still sets the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iflag <= '0;
        end else begin
            for (int k = 0; k < NUM_MATCH; k++) begin
                if (hit[k] && mctrl.irq[k]) begin
                    iflag[k] <= 1'b1;
                end else if (wr_en && paddr == OFS_IFLAG && pwdata[k]) begin
                    iflag[k] <= 1'b0;
                end
            end
        end
    end

    assign irq_pending = |iflag;

    // Output level per channel. Single edge: set on cycle match, clear on own
    // match. Double edge: set on match n-1, clear on match n. The clearing
    // edge is applied last so it wins a same-count collision.
    always_comb begin
        for (int n = 1; n <= NUM_OUT; n++) begin
            next_out[n] = pwm_out[n];
            if (!octrl.en[n-1]) begin
                next_out[n] = 1'b0;
            end else if (octrl.dbl[n-1]) begin
                if (hit[n-1]) begin
                    next_out[n] = 1'b1;
                end
                if (hit[n]) begin
                    next_out[n] = 1'b0;
                end
            end else begin
                if (hit[0]) begin
                    next_out[n] = 1'b1;
                end
                if (hit[n]) begin
                    next_out[n] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= '0;
        end else begin
            pwm_out <= next_out;
        end
    end

    // Read data registered during setup so it stands in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= CNT_ZERO;
        end else if (rd_en) begin
            prdata <= CNT_ZERO;
            if (paddr == OFS_CTRL) begin
                prdata[CTRL_RUN] <= run;
            end else if (paddr == OFS_COUNT) begin
                prdata <= count;
            end else if (paddr == OFS_MCTRL) begin
                for (int k = 0; k < NUM_MATCH; k++) begin
                    prdata[MC_W*k + MC_IRQ]  <= mctrl.irq[k];
                    prdata[MC_W*k + MC_RST]  <= mctrl.rst[k];
                    prdata[MC_W*k + MC_STOP] <= mctrl.stop[k];
                end
            end else if (paddr == OFS_IFLAG) begin
                prdata[NUM_MATCH-1:0] <= iflag;
            end else if (paddr == OFS_OCTRL) begin
                prdata[NUM_OUT-1:0] <= octrl.dbl;
                prdata[OC_EN_LSB +: NUM_OUT] <= octrl.en;
            end else if (paddr == OFS_OUTSTAT) begin
                prdata[NUM_OUT-1:0] <= pwm_out;
            end else if (match_index(paddr) != NUM_MATCH) begin
                prdata <= match_val[match_index(paddr)];
            end
        end
    end

    // Checks. Helper terms only feed the assertions, so they cost no logic in silicon
    assign irq_hit     = hit & mctrl.irq;
    assign any_irq_hit = |irq_hit;
    assign ctrl_wr     = wr_en && (paddr == OFS_CTRL);
    assign clr_mask    = (wr_en && paddr == OFS_IFLAG) ? pwdata[NUM_MATCH-1:0] : '0;
    assign clr_only    = clr_mask & ~irq_hit;

    // Counter stepping, restart and halt
    a_rst_to_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (any_rst && !ctrl_wr) |=> count == CNT_ZERO)
        else $error("count not zero after reset match");
    a_cycle_wraps: assert property (
        @(posedge pclk) disable iff (!presetn)
        (hit[0] && mctrl.rst[0] && !wr_en) |=> count == CNT_ZERO)
        else $error("cycle match did not restart count");
    a_count_steps: assert property (
        @(posedge pclk) disable iff (!presetn)
        (run && !any_rst && !any_stop && !wr_en) |=> count == $past(count) + CNT_ONE)
        else $error("count did not advance");
    a_idle_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!run && !ctrl_wr) |=> count == $past(count))
        else $error("stopped counter moved");
    a_stop_halts: assert property (
        @(posedge pclk) disable iff (!presetn)
        any_stop |=> !run)
        else $error("stop match left counter running");
    a_stop_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        (any_stop && !any_rst && !ctrl_wr) |=> count == $past(count))
        else $error("stop match did not hold the count");
    a_stop_keeps: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!run && !ctrl_wr) |=> !run)
        else $error("counter restarted without a control write");
    a_clear_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl_wr && pwdata[CTRL_CLR]) |=> count == CNT_ZERO)
        else $error("count clear did not take effect");
    a_run_starts: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl_wr && pwdata[CTRL_RUN] && !any_stop) |=> run)
        else $error("run write did not start counter");

    // Pending flags: set by enabled matches, kept until a write of one
    a_flag_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        any_irq_hit |=> (iflag & $past(irq_hit)) == $past(irq_hit))
        else $error("pending flag not set on match");
    a_flag_clears: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clr_only != '0) |=> (iflag & $past(clr_only)) == '0)
        else $error("pending flag not cleared by write");
    a_flag_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        (($past(iflag) & ~iflag) & ~$past(clr_mask)) == '0)
        else $error("pending flag dropped without a clear");
    a_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(irq_pending) |-> $past(any_irq_hit))
        else $error("irq output rose without an enabled match");

    // Read data loaded in setup must show the state seen at that edge
    a_read_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == OFS_COUNT) |=> prdata == $past(count))
        else $error("count read returned wrong value");
    a_read_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == OFS_IFLAG) |=> prdata[NUM_MATCH-1:0] == $past(iflag))
        else $error("flag read returned wrong value");
    a_read_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == OFS_OUTSTAT) |=> prdata[NUM_OUT-1:0] == $past(pwm_out))
        else $error("output status read returned wrong value");

    // Output edges on the channels the bench drives hardest
    a_single_rise: assert property (
        @(posedge pclk) disable iff (!presetn)
        (hit[0] && octrl.en[0] && !octrl.dbl[0] && !hit[1]) |=> pwm_out[1])
        else $error("single edge output not high at cycle start");
    a_edge_fall: assert property (
        @(posedge pclk) disable iff (!presetn)
        (hit[2] && octrl.en[1]) |=> !pwm_out[2])
        else $error("edge match did not drive output low");
    a_dbl_rise: assert property (
        @(posedge pclk) disable iff (!presetn)
        (hit[1] && octrl.en[1] && octrl.dbl[1] && !hit[2]) |=> pwm_out[2])
        else $error("double edge output did not rise");

    // Every channel: low when off, clear beats set, level holds between edges
    genvar gc;
    generate
        for (gc = 1; gc <= NUM_OUT; gc++) begin : g_chk_out
            a_off_low: assert property (
                @(posedge pclk) disable iff (!presetn)
                !octrl.en[gc-1] |=> !pwm_out[gc])
                else $error("disabled output not low");
            a_fall_wins: assert property (
                @(posedge pclk) disable iff (!presetn)
                (octrl.en[gc-1] && hit[gc]) |=> !pwm_out[gc])
                else $error("clearing match did not win");
            a_single_set: assert property (
                @(posedge pclk) disable iff (!presetn)
                (octrl.en[gc-1] && !octrl.dbl[gc-1] && hit[0] && !hit[gc]) |=> pwm_out[gc])
                else $error("single edge output not set by cycle match");
            a_double_set: assert property (
                @(posedge pclk) disable iff (!presetn)
                (octrl.en[gc-1] && octrl.dbl[gc-1] && hit[gc-1] && !hit[gc]) |=> pwm_out[gc])
                else $error("double edge output not set by its rising match");
            a_level_holds: assert property (
                @(posedge pclk) disable iff (!presetn)
                (octrl.en[gc-1] && !hit[gc] && !(octrl.dbl[gc-1] ? hit[gc-1] : hit[0]))
                |=> pwm_out[gc] == $past(pwm_out[gc]))
                else $error("output changed without an edge match");
        end
    endgenerate

    // Every match register: storage, read back and its three actions
    genvar gm;
    generate
        for (gm = 0; gm < NUM_MATCH; gm++) begin : g_chk_match
            a_match_store: assert property (
                @(posedge pclk) disable iff (!presetn)
                (wr_en && match_index(paddr) == gm) |=> match_val[gm] == $past(pwdata))
                else $error("match value write lost");
            a_match_keeps: assert property (
                @(posedge pclk) disable iff (!presetn)
                !(wr_en && match_index(paddr) == gm) |=> match_val[gm] == $past(match_val[gm]))
                else $error("match value changed without a write");
            a_reset_act: assert property (
                @(posedge pclk) disable iff (!presetn)
                (hit[gm] && mctrl.rst[gm]) |=> count == CNT_ZERO)
                else $error("reset action did not zero the count");
            a_stop_act: assert property (
                @(posedge pclk) disable iff (!presetn)
                (hit[gm] && mctrl.stop[gm]) |=> !run)
                else $error("stop action did not halt the counter");
            a_flag_act: assert property (
                @(posedge pclk) disable iff (!presetn)
                (hit[gm] && mctrl.irq[gm]) |=> iflag[gm])
                else $error("interrupt option did not set its flag");
            a_cont_act: assert property (
                @(posedge pclk) disable iff (!presetn)
                (hit[gm] && !any_rst && !any_stop && !wr_en) |=> count == $past(count) + CNT_ONE)
                else $error("continue action did not keep counting");
            a_read_match: assert property (
                @(posedge pclk) disable iff (!presetn)
                (rd_en && match_index(paddr) == gm) |=> prdata == $past(match_val[gm]))
                else $error("match value read returned wrong value");
        end
    endgenerate
endmodule

//--- verif/mbpm_load_model.sv
// Load model on the pulse outputs: measures high time and period of each channel
`timescale 1ns/1ps
module mbpm_load_model
    import mbpm_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [NUM_OUT:1]      pwm_out,
    output logic      [NUM_OUT:1][7:0] hi_len,
    output logic      [NUM_OUT:1][7:0] per_len
);
    logic [NUM_OUT:1]      prev;
    logic [NUM_OUT:1][7:0] hi_cnt;
    logic [NUM_OUT:1][7:0] run_cnt;

    // A load only sees levels; lengths are kept in whole clock cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev    <= '0;
            hi_cnt  <= '0;
            run_cnt <= '0;
            hi_len  <= '0;
            per_len <= '0;
        end else begin
            prev <= pwm_out;
            for (int n = 1; n <= NUM_OUT; n++) begin
                run_cnt[n] <= (pwm_out[n] && !prev[n]) ? 8'h01 : run_cnt[n] + 8'h01;
                if (pwm_out[n] && !prev[n]) begin
                    per_len[n] <= run_cnt[n];
                end
                hi_cnt[n] <= pwm_out[n] ? (prev[n] ? hi_cnt[n] + 8'h01 : 8'h01) : 8'h00;
                if (!pwm_out[n] && prev[n]) begin
                    hi_len[n] <= hi_cnt[n];
                end
            end
        end
    end
endmodule

//--- verif/tb_top.sv
// Self-checking bench: APB tasks, read scoreboard queue and pulse checks
`timescale 1ns/1ps
module tb_top
    import mbpm_pkg::*;
;
    logic                  pclk = 1'b0;
    logic                  presetn, psel, penable, pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, seed_val;
    logic                  pready, pslverr, irq_pending;
    logic [NUM_OUT:1]      pwm_out;
    logic [NUM_OUT:1][7:0] hi_len, per_len;
    logic [32:0]           exp_q[$];
    logic [11:0]           ofs[7] = '{OFS_CTRL, OFS_COUNT, OFS_MCTRL, OFS_IFLAG,
                                      OFS_OCTRL, OFS_OUTSTAT, OFS_MATCH0};
    int                    err_count = 0;
    int                    total_checks = 0;
    logic [31:0]           m0, a, b, c;

    always #5 pclk = ~pclk;

    mbpm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out(pwm_out), .irq_pending(irq_pending));
    mbpm_load_model u_load (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out),
        .hi_len(hi_len), .per_len(per_len));

    task automatic check(input logic [32:0] seen, input logic [32:0] expv);
        total_checks++;
        if (seen !== expv) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Reads note their expected {pslverr, prdata} before the access phase
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                       input logic [32:0] expv);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        if (!wr) exp_q.push_back(expv);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Scoreboard: oldest note against each completed read
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        seed_val = $urandom(32'h19FA279C);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ofs[i]) apb(1'b0, ofs[i], 32'h0, 33'h0);
        apb(1'b0, 12'h040, 32'h0, {1'b1, 32'h0});
        m0 = 8 + $urandom_range(7);
        a  = 1 + $urandom_range(2);
        b  = 4 + $urandom_range(3);
        c  = 1 + $urandom_range(6);
        // Ch1/3 single, ch2 positive and ch4 negative double, ch6 set and clear collide
        apb(1'b1, OFS_MATCH0, m0, 33'h0);
        apb(1'b1, OFS_MATCH0 + 12'h004, a, 33'h0);
        apb(1'b1, OFS_MATCH0 + 12'h008, b, 33'h0);
        apb(1'b1, OFS_MATCH0 + 12'h00C, b, 33'h0);
        apb(1'b1, OFS_MATCH0 + 12'h010, a, 33'h0);
        apb(1'b1, OFS_MATCH0 + 12'h018, m0, 33'h0);
        apb(1'b1, OFS_MCTRL, 32'h00000003, 33'h0);
        apb(1'b1, OFS_OCTRL, 32'h00002F0A, 33'h0);
        apb(1'b1, OFS_CTRL, 32'h00000001, 33'h0);
        repeat (4 * (m0 + 1)) @(posedge pclk);
        @(negedge pclk);
        check(hi_len[1], a + 1);
        check(hi_len[3], b + 1);
        check(hi_len[2], b - a);
        check(hi_len[4], m0 + 1 - (b - a));
        for (int n = 1; n <= 4; n++) check(per_len[n], m0 + 1);
        check({hi_len[6], per_len[6], pwm_out[6]}, 33'h0);
        check({hi_len[5], pwm_out[5]}, 33'h0);
        // Stop on match 5 with its interrupt option, counter must hold there
        apb(1'b1, OFS_CTRL, 32'h00000000, 33'h0);
        apb(1'b1, OFS_CTRL, 32'h00000002, 33'h0);
        apb(1'b0, OFS_COUNT, 32'h0, 33'h0);
        apb(1'b1, OFS_MATCH0 + 12'h014, c, 33'h0);
        apb(1'b1, OFS_MCTRL, 32'h00028003, 33'h0);
        apb(1'b1, OFS_CTRL, 32'h00000001, 33'h0);
        repeat (2 * (m0 + 1)) @(posedge pclk);
        apb(1'b0, OFS_COUNT, 32'h0, {1'b0, c});
        apb(1'b0, OFS_CTRL, 32'h0, 33'h0);
        apb(1'b0, OFS_IFLAG, 32'h0, 33'h21);
        check(irq_pending, 1'b1);
        apb(1'b1, OFS_IFLAG, 32'h00000021, 33'h0);
        apb(1'b0, OFS_IFLAG, 32'h0, 33'h0);
        check(irq_pending, 1'b0);
        repeat (2) @(posedge pclk);
        tally_and_finish();
    end
endmodule
